// ### common/card_cfg_regs.svh
// Notes on behaviour
// - partial flags read zero; whole blocks only
// - write misalign flag zero; no boundary crossing
// - read misalign flag zero; no boundary crossing
// - driver stage flag reflects register presence
// - capacity is (size field plus one) times 512K
// - top six size bits held zero
// - single unit erase flag one; 512-byte units
// - sector size reads 7Fh; host ignores it
// - protect group span and enable read zero
// - write speed multiplier reads 2h
// - host uses fixed 250 ms write timeout
// - max write block length reads 9h
// - format fields read zero; host ignores them
// - copy flag one-time settable, never clears
// - permanent lock sticky, blocks write and erase
// - temporary lock toggles, blocks write and erase
// - host recomputes checksum on every image program, not on timing change
// - writable 16-bit card address, resets zero
// - select with address zero means standby
// - driver stage register resets to 0x404
// - fields unsigned, leftmost bit most significant
// - transfer speed 032h default, 05Ah high speed
`ifndef CARD_CFG_REGS_SVH
`define CARD_CFG_REGS_SVH

// fixed field values of the card specific data image
`define IMG_STRUCT_VER 2'h1
`define IMG_ACCESS_TIME 8'h0e
`define IMG_ACCESS_CLKS 8'h00
`define IMG_SPEED_DEFAULT 8'h32
`define IMG_SPEED_HIGH 8'h5a
`define IMG_CLASSES 12'h5b5
`define IMG_READ_LEN 4'h9
`define IMG_WRITE_LEN 4'h9
`define IMG_SECTOR_SIZE 7'h7f
`define IMG_PROTECT_SPAN 7'h00
`define IMG_SPEED_MULT 3'h2

// positions of the writable bits, same in the program argument and the image, and of the size field in the image
`define IMG_COPY_BIT 14
`define IMG_PERM_BIT 13
`define IMG_TMP_BIT 12
`define IMG_CRC_MSB 7
`define IMG_CRC_LSB 1
`define IMG_SIZE_MSB 69
`define IMG_SIZE_LSB 48

// reset values
`define CARD_ADDR_RESET 16'h0000
`define DRIVER_STAGE_RESET 16'h0404

// sizes
`define BLOCK_LOG2 9
`define CAP_UNIT_LOG2 19

// timing
`define WRITE_TIMEOUT_MS 250
`define CLK_MHZ 200
`define WRITE_TIMEOUT_CYCLES (`WRITE_TIMEOUT_MS * `CLK_MHZ * 1000)

`endif

// ### common/card_cfg_pkg.sv
package card_cfg_pkg;

  // commands the host may issue on the card bus
  typedef enum logic [3:0] {
    OP_READ_IMAGE = 4'h0,
    OP_PROGRAM_IMAGE = 4'h1,
    OP_SET_ADDR = 4'h2,
    OP_SELECT = 4'h3,
    OP_SET_STAGE = 4'h4,
    OP_SET_TIMING = 4'h5,
    OP_GO_IDLE = 4'h6,
    OP_READ = 4'h7,
    OP_WRITE = 4'h8,
    OP_ERASE = 4'h9
  } op_t;

  // card side state
  typedef struct packed {
    logic selected;
    logic high_speed;
    logic copy;
    logic perm;
    logic tmp;
    logic [6:0] crc;
    logic [15:0] card_addr;
    logic [15:0] driver_stage;
    logic resp_valid;
    logic resp_ok;
    logic [127:0] resp_data;
    logic go_valid;
    op_t go_op;
    logic [31:0] go_addr;
    logic [15:0] go_len;
  } card_state_t;

  // host sequencer states, one-hot
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_FETCH = 4'b0010,
    H_SEND = 4'b0100,
    H_WAIT = 4'b1000
  } host_phase_t;

  // host side state
  typedef struct packed {
    host_phase_t phase;
    logic cmd_valid;
    op_t op;
    logic [31:0] arg;
    logic [15:0] len;
    logic [31:0] timer;
    logic done;
    logic done_ok;
    logic timed_out;
    logic [127:0] done_data;
    logic [41:0] capacity;
  } host_state_t;

  // checksum over the upper 120 image bits, x^7 + x^3 + 1, msb first
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

endpackage

// ### common/card_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
// command bus between host controller and card
interface card_cfg_if (
  input wire logic clk,
  input wire logic rst_n
);
  import card_cfg_pkg::*;

  logic cmd_valid; // one-cycle command strobe
  op_t cmd_op; // command code
  logic [31:0] cmd_arg; // argument
  logic [15:0] cmd_len; // byte count for data access
  logic resp_valid; // one-cycle answer strobe
  logic resp_ok; // command accepted
  logic [127:0] resp_data; // answer payload

  modport card (
    input clk, rst_n, cmd_valid, cmd_op, cmd_arg, cmd_len,
    output resp_valid, resp_ok, resp_data
  );

  modport host (
    input clk, rst_n, resp_valid, resp_ok, resp_data,
    output cmd_valid, cmd_op, cmd_arg, cmd_len
  );
endinterface
`default_nettype wire

// ### hw/card_config_registers.sv
`timescale 1ns/100ps
`default_nettype none
`include "card_cfg_regs.svh"
// card end: config image, card address and driver stage registers plus access gate
module card_config_registers
  import card_cfg_pkg::*;
#(
  parameter logic DRIVER_STAGE_PRESENT = 1'b1, // driver stage built in
  parameter logic [15:0] SIZE_LOW = 16'h1fff, // low capacity field bits
  parameter logic COPY_INIT = 1'b0 // copy flag as shipped
) (
  card_cfg_if.card bus,
  input wire logic [15:0] proposed_addr,
  output logic selected,
  output logic high_speed,
  output logic [15:0] card_addr,
  output logic [15:0] driver_stage,
  output logic write_locked,
  output logic access_go,
  output op_t access_op,
  output logic [31:0] access_addr,
  output logic [15:0] access_len
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration image

  // capacity field, top bits forced low to cap the card at 32 GB
  localparam logic [21:0] SIZE_FIELD = {6'h00, SIZE_LOW};

  // assemble the 128-bit image; every fixed field is a constant here
  // reserved bits stay zero from the clear at the top, so they never need a write
  function automatic logic [127:0] build_image(
    input logic hs,
    input logic cp,
    input logic pm,
    input logic tp,
    input logic [6:0] ck
  );
    logic [127:0] v;
    v = '0;
    v[127:126] = `IMG_STRUCT_VER;
    v[119:112] = `IMG_ACCESS_TIME;
    v[111:104] = `IMG_ACCESS_CLKS;
    v[103:96] = hs ? `IMG_SPEED_HIGH : `IMG_SPEED_DEFAULT;
    v[95:84] = `IMG_CLASSES;
    v[83:80] = `IMG_READ_LEN;
    v[79] = 1'b0;
    v[78] = 1'b0;
    v[77] = 1'b0;
    v[76] = DRIVER_STAGE_PRESENT;
    v[`IMG_SIZE_MSB:`IMG_SIZE_LSB] = SIZE_FIELD;
    v[46] = 1'b1;
    v[45:39] = `IMG_SECTOR_SIZE;
    v[38:32] = `IMG_PROTECT_SPAN;
    v[31] = 1'b0;
    v[28:26] = `IMG_SPEED_MULT;
    v[25:22] = `IMG_WRITE_LEN;
    v[21] = 1'b0;
    v[15] = 1'b0;
    // the only flag bits a host can move
    v[`IMG_COPY_BIT] = cp;
    v[`IMG_PERM_BIT] = pm;
    v[`IMG_TMP_BIT] = tp;
    v[11:10] = 2'h0;
    v[`IMG_CRC_MSB:`IMG_CRC_LSB] = ck;
    v[0] = 1'b1;
    return v;
  endfunction

  // checksum of the shipped contents, so reset leaves a consistent image
  localparam logic [127:0] IMAGE_BASE = build_image(1'b0, COPY_INIT, 1'b0, 1'b0, 7'h00);
  localparam logic [6:0] INIT_CRC = crc7(IMAGE_BASE[127:8]);

  ////////////////////////////////////////////////////////////////////////////
  // state

  card_state_t s; // registered state
  card_state_t next_s; // next state
  logic [127:0] image_now; // live image
  logic aligned; // access starts and spans whole blocks
  logic is_change; // write or erase

  // live image follows the writable bits and the timing mode
  assign image_now = build_image(s.high_speed, s.copy, s.perm, s.tmp, s.crc);

  // whole blocks only: non-zero length, both ends on a block edge
  assign aligned = (bus.cmd_len != 16'h0000) &&
    (bus.cmd_len[`BLOCK_LOG2-1:0] == '0) &&
    (bus.cmd_arg[`BLOCK_LOG2-1:0] == '0);

  // content changing commands share the lock check
  assign is_change = (bus.cmd_op == OP_WRITE) || (bus.cmd_op == OP_ERASE);

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  // every command is answered on the next edge; strobes last one cycle
  always_comb begin
    next_s = s;
    next_s.resp_valid = 1'b0;
    next_s.go_valid = 1'b0;
    if (bus.cmd_valid) begin
      // default answer: accepted, empty payload
      next_s.resp_valid = 1'b1;
      next_s.resp_ok = 1'b1;
      next_s.resp_data = '0;
      case (bus.cmd_op)
        OP_READ_IMAGE: begin
          next_s.resp_data = image_now;
        end
        OP_PROGRAM_IMAGE: begin
          // only the writable bits are taken; fixed fields never move
          next_s.copy = s.copy | bus.cmd_arg[`IMG_COPY_BIT];
          next_s.perm = s.perm | bus.cmd_arg[`IMG_PERM_BIT];
          next_s.tmp = bus.cmd_arg[`IMG_TMP_BIT];
          next_s.crc = bus.cmd_arg[`IMG_CRC_MSB:`IMG_CRC_LSB];
          // the answer shows the image as it stood before this change
          next_s.resp_data = image_now;
        end
        OP_SET_ADDR: begin
          // the card publishes the address it proposes
          next_s.card_addr = proposed_addr;
          next_s.resp_data[15:0] = proposed_addr;
        end
        OP_SELECT: begin
          if (bus.cmd_arg[31:16] == 16'h0000) begin
            // reserved address sends every card to standby
            next_s.selected = 1'b0;
          end else begin
            next_s.selected = (bus.cmd_arg[31:16] == s.card_addr);
            next_s.resp_ok = (bus.cmd_arg[31:16] == s.card_addr);
          end
        end
        OP_SET_STAGE: begin
          // without the register the value has nowhere to go, so refuse it
          if (DRIVER_STAGE_PRESENT) begin
            next_s.driver_stage = bus.cmd_arg[15:0];
          end else begin
            // no register to take it
            next_s.resp_ok = 1'b0;
          end
        end
        OP_SET_TIMING: begin
          next_s.high_speed = bus.cmd_arg[0];
        end
        OP_GO_IDLE: begin
          // back to default timing, speed field returns to 032h
          next_s.high_speed = 1'b0;
          next_s.selected = 1'b0;
        end
        OP_READ, OP_WRITE, OP_ERASE: begin
          // refuse partial or straddling access, and changes under a lock
          if (!s.selected || !aligned) begin
            next_s.resp_ok = 1'b0;
          end else if (is_change && (s.perm || s.tmp)) begin
            next_s.resp_ok = 1'b0;
          end else begin
            next_s.go_valid = 1'b1;
            next_s.go_op = bus.cmd_op;
            next_s.go_addr = bus.cmd_arg;
            next_s.go_len = bus.cmd_len;
          end
        end
        default: begin
          // unknown code is refused
          next_s.resp_ok = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // power-up defaults; locks open, address zero, driver stage 0x404
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      s <= '0;
      s.copy <= COPY_INIT;
      s.crc <= INIT_CRC;
      s.card_addr <= `CARD_ADDR_RESET;
      s.driver_stage <= `DRIVER_STAGE_RESET;
      s.go_op <= OP_READ;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign bus.resp_valid = s.resp_valid;
  assign bus.resp_ok = s.resp_ok;
  assign bus.resp_data = s.resp_data;
  assign selected = s.selected;
  assign high_speed = s.high_speed;
  assign card_addr = s.card_addr;
  // reads as the reset value when the register is absent
  assign driver_stage = s.driver_stage;
  assign write_locked = s.perm | s.tmp;
  assign access_go = s.go_valid;
  assign access_op = s.go_op;
  assign access_addr = s.go_addr;
  assign access_len = s.go_len;

endmodule // card_config_registers
`default_nettype wire

// ### hw/card_cfg_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "card_cfg_regs.svh"
// host end: issues commands, fixes the checksum on image program, times out writes
module card_cfg_host
  import card_cfg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `WRITE_TIMEOUT_CYCLES, // write wait
  parameter int unsigned ANSWER_CYCLES = 64 // wait for other answers
) (
  card_cfg_if.host bus,
  input wire logic req_valid,
  input wire op_t req_op,
  input wire logic [31:0] req_arg,
  input wire logic [15:0] req_len,
  output logic req_ready,
  output logic done,
  output logic done_ok,
  output logic timed_out,
  output logic [127:0] done_data,
  output logic [41:0] capacity
);

  host_state_t s; // registered state
  host_state_t next_s; // next state
  logic [127:0] patched; // fetched image with user bits merged

  // merge the writable bits into the last fetched image; the sticky bits keep a
  // set value, so the new checksum must cover what the card will really hold
  always_comb begin
    patched = bus.resp_data;
    patched[`IMG_COPY_BIT] = bus.resp_data[`IMG_COPY_BIT] | s.arg[`IMG_COPY_BIT];
    patched[`IMG_PERM_BIT] = bus.resp_data[`IMG_PERM_BIT] | s.arg[`IMG_PERM_BIT];
    patched[`IMG_TMP_BIT] = s.arg[`IMG_TMP_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // program is done as fetch, patch, recompute checksum, send
  always_comb begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.done = 1'b0;
    case (s.phase)
      H_IDLE: begin
        if (req_valid) begin
          next_s.arg = req_arg;
          next_s.len = req_len;
          next_s.op = req_op;
          next_s.timer = '0;
          next_s.timed_out = 1'b0;
          next_s.cmd_valid = 1'b1;
          if (req_op == OP_PROGRAM_IMAGE) begin
            next_s.op = OP_READ_IMAGE;
            next_s.phase = H_FETCH;
          end else begin
            next_s.phase = H_WAIT;
          end
        end
      end
      H_FETCH: begin
        if (bus.resp_valid) begin
          // new checksum over the patched upper bits
          next_s.arg = {16'h0000, patched[15:8], crc7(patched[127:8]), 1'b1};
          next_s.op = OP_PROGRAM_IMAGE;
          next_s.phase = H_SEND;
        end
      end
      H_SEND: begin
        next_s.cmd_valid = 1'b1;
        next_s.timer = '0;
        next_s.phase = H_WAIT;
      end
      H_WAIT: begin
        next_s.timer = s.timer + 32'd1;
        if (bus.resp_valid) begin
          next_s.done = 1'b1;
          next_s.done_ok = bus.resp_ok;
          next_s.done_data = bus.resp_data;
          if (s.op == OP_READ_IMAGE) begin
            // capacity from the size field only; format and sector ignored
            next_s.capacity = {20'h00000, bus.resp_data[`IMG_SIZE_MSB:`IMG_SIZE_LSB]} + 42'd1;
            next_s.capacity = next_s.capacity << `CAP_UNIT_LOG2;
          end
          next_s.phase = H_IDLE;
        end else if ((s.op == OP_WRITE) ? (s.timer >= TIMEOUT_CYCLES - 1)
                                        : (s.timer >= ANSWER_CYCLES - 1)) begin
          // fixed write timeout, the speed multiplier is never used
          next_s.done = 1'b1;
          next_s.done_ok = 1'b0;
          next_s.timed_out = 1'b1;
          next_s.phase = H_IDLE;
        end
      end
      default: begin
        next_s.phase = H_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      s <= '0;
      s.phase <= H_IDLE;
      s.op <= OP_READ_IMAGE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.cmd_valid = s.cmd_valid;
  assign bus.cmd_op = s.op;
  assign bus.cmd_arg = s.arg;
  assign bus.cmd_len = s.len;
  assign req_ready = (s.phase == H_IDLE);
  assign done = s.done;
  assign done_ok = s.done_ok;
  assign timed_out = s.timed_out;
  assign done_data = s.done_data;
  assign capacity = s.capacity;

endmodule // card_cfg_host
`default_nettype wire

// ### bench/card_config_registers_properties.sv
`timescale 1ns/100ps
`default_nettype none
// watches the command bus between the host end and the card end
module card_config_registers_properties
  import card_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire op_t cmd_op,
  input wire logic [31:0] cmd_arg,
  input wire logic [15:0] cmd_len,
  input wire logic resp_valid,
  input wire logic resp_ok,
  input wire logic [127:0] resp_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // an answer to an image read lands on this edge
  sequence image_seen;
    resp_valid && $past(cmd_op) == OP_READ_IMAGE;
  endsequence
  // data access whose length or start is not a whole block
  sequence part_access;
    cmd_valid && cmd_op inside {OP_READ, OP_WRITE, OP_ERASE} && (cmd_len[8:0] != 9'h000 || cmd_arg[8:0] != 9'h000);
  endsequence
  ////////////////////////////////////////
  a_answer_next: assert property (cmd_valid |=> resp_valid)
    else $error("command not answered next cycle");
  a_answer_cause: assert property (resp_valid |-> $past(cmd_valid))
    else $error("answer without a command");
  a_block_flags: assert property (image_seen |-> resp_data[79:76] == 4'h1 && !resp_data[21])
    else $error("block access flags wrong");
  a_size_top: assert property (image_seen |-> resp_data[69:64] == 6'h00)
    else $error("top size bits not zero");
  a_erase_fields: assert property (image_seen |-> resp_data[46:31] == {1'b1, 7'h7f, 7'h00, 1'b0})
    else $error("erase or group fields wrong");
  a_write_fields: assert property (image_seen |-> resp_data[28:22] == {3'h2, 4'h9})
    else $error("speed factor or write length wrong");
  a_format_zero: assert property (image_seen |-> !resp_data[15] && resp_data[11:10] == 2'h0)
    else $error("format fields not zero");
  a_partial_refused: assert property (part_access |=> resp_valid && !resp_ok)
    else $error("partial or misaligned access accepted");
  // main scenarios reached
  cover property (image_seen);
  cover property (part_access ##1 !resp_ok);
  cover property (cmd_valid && cmd_op == OP_SELECT && cmd_arg[31:16] == 16'h0000);
endmodule // card_config_registers_properties
`default_nettype wire

// ### bench/card_config_registers_tb.sv
`timescale 1ns/100ps
`default_nettype none
// host end driven from its user side, card end behind it
module card_config_registers_tb
  import card_cfg_pkg::*;
;
  localparam logic [15:0] SIZE_LOW = 16'h1fff; // low capacity bits
  localparam logic [15:0] NEW_ADDR = 16'h1234; // address the card publishes
  logic clk; // 200 MHz
  logic rst_n; // active low
  logic req_valid;
  op_t req_op;
  logic [31:0] req_arg;
  logic [15:0] req_len;
  logic req_ready;
  logic done;
  logic done_ok;
  logic timed_out;
  logic [127:0] done_data;
  logic [41:0] capacity;
  logic [15:0] proposed_addr;
  logic selected;
  logic high_speed;
  logic [15:0] card_addr;
  logic [15:0] driver_stage;
  logic write_locked;
  op_t access_op;
  logic access_go;
  logic [31:0] access_addr;
  logic [15:0] access_len;
  int miscompares;
  int checks_done;
  int go_seen = 0; // accepted accesses counted so far
  ////////////////////////////////////////
  card_cfg_if i_card_cfg_if (.clk(clk), .rst_n(rst_n));
  card_config_registers #(.DRIVER_STAGE_PRESENT(1'b1), .SIZE_LOW(SIZE_LOW), .COPY_INIT(1'b0))
    i_card_config_registers (
    .bus(i_card_cfg_if), .proposed_addr(proposed_addr), .selected(selected), .high_speed(high_speed),
    .card_addr(card_addr), .driver_stage(driver_stage), .write_locked(write_locked), .access_go(access_go),
    .access_op(access_op), .access_addr(access_addr), .access_len(access_len));
  // small write timeout keeps a hang short
  card_cfg_host #(.TIMEOUT_CYCLES(100), .ANSWER_CYCLES(64)) i_card_cfg_host (
    .bus(i_card_cfg_if), .req_valid(req_valid), .req_op(req_op), .req_arg(req_arg), .req_len(req_len),
    .req_ready(req_ready), .done(done), .done_ok(done_ok), .timed_out(timed_out), .done_data(done_data),
    .capacity(capacity));
  card_config_registers_properties i_card_config_registers_properties (
    .clk(clk), .rst_n(rst_n), .cmd_valid(i_card_cfg_if.cmd_valid), .cmd_op(i_card_cfg_if.cmd_op),
    .cmd_arg(i_card_cfg_if.cmd_arg), .cmd_len(i_card_cfg_if.cmd_len), .resp_valid(i_card_cfg_if.resp_valid),
    .resp_ok(i_card_cfg_if.resp_ok), .resp_data(i_card_cfg_if.resp_data));
  ////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // accepted accesses are one-cycle pulses, long gone when done is seen, so count them
  always @(posedge clk) begin
    if (access_go === 1'b1) begin
      go_seen <= go_seen + 1;
    end
  end
  // own checksum, x^7 + x^3 + 1, msb first
  function automatic logic [6:0] crc_ref(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one request on the user side, bounded waits for ready and done
  task automatic request(input op_t op, input logic [31:0] arg, input logic [15:0] len);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (req_ready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    req_valid = 1'b1;
    req_op = op;
    req_arg = arg;
    req_len = len;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    // a timed-out refusal would otherwise pass as a real one
    check("timed_out", 1'b0, timed_out);
  endtask
  task automatic op_ok(input op_t op, input logic [31:0] arg, input logic [15:0] len, input logic exp);
    request(op, arg, len);
    check(op.name(), exp, done_ok);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    check("card_addr", 16'h0000, card_addr);
    check("driver_stage", 16'h0404, driver_stage);
    check("write_locked", 1'b0, write_locked);
    $display("done reset values");
  endtask
  // block, size, erase, protect, write and format fields of the image, the speed byte, the checksum and the capacity
  task automatic t_csd();
    op_ok(OP_READ_IMAGE, 32'h0, 16'h0, 1'b1);
    check("partial", 2'b00, {done_data[79], done_data[21]});
    check("write misalign", 1'b0, done_data[78]);
    check("read misalign", 1'b0, done_data[77]);
    check("stage flag", 1'b1, done_data[76]);
    check("size", {6'h00, SIZE_LOW}, done_data[69:48]);
    check("capacity", ({26'h0, SIZE_LOW} + 42'h1) << 19, capacity);
    check("erase unit", 1'b1, done_data[46]);
    check("sector", 7'h7f, done_data[45:39]);
    check("group", 8'h00, done_data[38:31]);
    check("speed mult", 3'h2, done_data[28:26]);
    check("write len", 4'h9, done_data[25:22]);
    check("format", 3'h0, {done_data[15], done_data[11:10]});
    check("speed", 8'h32, done_data[103:96]);
    check("crc", crc_ref(done_data[127:8]), done_data[7:1]);
    $display("done image read");
  endtask
  // speed byte follows timing mode and returns on idle
  task automatic t_timing();
    op_ok(OP_SET_TIMING, 32'h1, 16'h0, 1'b1);
    check("high_speed", 1'b1, high_speed);
    request(OP_READ_IMAGE, 32'h0, 16'h0);
    check("speed hs", 8'h5a, done_data[103:96]);
    request(OP_GO_IDLE, 32'h0, 16'h0);
    request(OP_READ_IMAGE, 32'h0, 16'h0);
    check("speed back", 8'h32, done_data[103:96]);
    $display("done timing");
  endtask
  // addressing, whole-block gate and reserved address zero
  task automatic t_access();
    logic [52:0] tab [13] = '{
      {OP_SET_ADDR, 32'h0, 16'h0, 1'b1}, {OP_SELECT, NEW_ADDR, 16'h0, 16'h0, 1'b1},
      {OP_WRITE, 32'h200, 16'h400, 1'b1}, {OP_WRITE, 32'h200, 16'h100, 1'b0},
      {OP_READ, 32'h200, 16'h1ff, 1'b0}, {OP_WRITE, 32'h201, 16'h200, 1'b0},
      {OP_READ, 32'h300, 16'h200, 1'b0}, {OP_ERASE, 32'h400, 16'h200, 1'b1},
      {OP_READ, 32'h0, 16'h200, 1'b1}, {OP_SELECT, 16'h4321, 16'h0, 16'h0, 1'b0},
      {OP_SELECT, NEW_ADDR, 16'h0, 16'h0, 1'b1}, {OP_SELECT, 32'h0, 16'h0, 1'b1},
      {OP_READ, 32'h0, 16'h200, 1'b0}};
    int go_start;
    // a wrong address deselects too, so reselect before address zero and let it alone deselect the card
    go_start = go_seen;
    foreach (tab[i]) begin
      op_ok(op_t'(tab[i][52:49]), tab[i][48:17], tab[i][16:1], tab[i][0]);
    end
    check("access_go count", 32'd3, go_seen - go_start);
    check("card_addr", NEW_ADDR, card_addr);
    check("selected", 1'b0, selected);
    check("access_len", 16'h0200, access_len);
    check("access_op", OP_READ, access_op);
    $display("done access gate");
  endtask
  // locks, sticky copy flag, fixed fields and the stage register
  task automatic t_locks();
    request(OP_SELECT, {NEW_ADDR, 16'h0}, 16'h0);
    op_ok(OP_PROGRAM_IMAGE, 32'h9c00, 16'h0, 1'b1);
    check("tmp lock", 1'b1, write_locked);
    op_ok(OP_WRITE, 32'h200, 16'h200, 1'b0);
    op_ok(OP_ERASE, 32'h200, 16'h200, 1'b0);
    request(OP_READ_IMAGE, 32'h0, 16'h0);
    check("fixed", 3'h0, {done_data[15], done_data[11:10]});
    check("crc new", crc_ref(done_data[127:8]), done_data[7:1]);
    request(OP_PROGRAM_IMAGE, 32'h0, 16'h0);
    op_ok(OP_WRITE, 32'h200, 16'h200, 1'b1);
    check("access_addr", 32'h200, access_addr);
    check("access_op", OP_WRITE, access_op);
    request(OP_PROGRAM_IMAGE, 32'h4000, 16'h0);
    request(OP_PROGRAM_IMAGE, 32'h0, 16'h0);
    request(OP_READ_IMAGE, 32'h0, 16'h0);
    check("copy", 1'b1, done_data[14]);
    check("crc copy", crc_ref(done_data[127:8]), done_data[7:1]);
    request(OP_PROGRAM_IMAGE, 32'h2000, 16'h0);
    request(OP_PROGRAM_IMAGE, 32'h0, 16'h0);
    op_ok(OP_WRITE, 32'h200, 16'h200, 1'b0);
    op_ok(OP_ERASE, 32'h200, 16'h200, 1'b0);
    op_ok(OP_SET_STAGE, 32'h0707, 16'h0, 1'b1);
    check("driver_stage", 16'h0707, driver_stage);
    $display("done locks");
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    req_valid = 1'b0;
    req_op = OP_READ_IMAGE;
    req_arg = 32'h0;
    req_len = 16'h0;
    proposed_addr = NEW_ADDR;
    rst_n = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_csd();
    t_timing();
    t_access();
    t_locks();
    end_of_test();
  end
endmodule // card_config_registers_tb
`default_nettype wire
